// [verif/spms_peer.sv]
// far-end model: a slave while the port is master, a master while it is slave
// assumes the bench resolves every line from the enables; lines seen as levels
`timescale 1ns/100ps
module spms_peer (
  // configuration
  input wire logic role_slave,
  input wire logic clock_polarity_bit,
  input wire logic clock_phase_bit,
  input wire logic [7:0] tx_byte,
  // resolved lines
  input wire logic sck,
  input wire logic ss_n,
  input wire logic mosi,
  input wire logic miso,
  // driven lines and received byte
  output logic sck_m,
  output logic ss_m,
  output logic mosi_m,
  output logic miso_s,
  output logic [7:0] rx
);
  // five system clocks per phase, above the two-clock sampling minimum
  localparam time HALF = 125;
  logic [7:0] sh;
  logic miso_q;
  logic started;
  initial {sck_m, mosi_m, miso_q, rx, sh, started, ss_m} = 21'h1;
  // a released line shows the inverse of its last bit, never a steady guess
  assign miso_s = (role_slave && !ss_n) ? miso_q : !miso_q;
  always @(negedge ss_n)
    if (role_slave)
    begin
      sh = tx_byte;
      miso_q = sh[7];
      started = 1'h0;
    end
  // sample on the edge that the phase picks, set up on the other one
  always @(sck)
    if (role_slave && !ss_n)
    begin
      if (sck == !(clock_polarity_bit ^ clock_phase_bit))
        rx = {rx[6:0], mosi};
      else
      begin
        if (started || !clock_phase_bit)
          sh = sh << 1;
        miso_q = sh[7];
        started = 1'h1;
      end
    end
  task automatic set_ss(logic v);
    ss_m = v;
  endtask
  // sel low leaves select high, so a deselected port should ignore sck
  task automatic send(logic [7:0] b, int n, logic sel);
    sck_m = clock_polarity_bit;
    #HALF;
    ss_m = !sel;
    if (!clock_phase_bit)
      mosi_m = b[7];
    #HALF;
    for (int i = 0; i < n; i++)
    begin
      sck_m = !clock_polarity_bit;
      if (clock_phase_bit)
        mosi_m = b[7 - i];
      else
        rx = {rx[6:0], miso};
      #HALF;
      sck_m = clock_polarity_bit;
      if (clock_phase_bit)
        rx = {rx[6:0], miso};
      else if (i < 7)
        mosi_m = b[6 - i];
      #HALF;
    end
    ss_m = 1'h1;
    mosi_m = !mosi_m;
  endtask
endmodule // spms_peer

// [verif/spms_port_bench.sv]
// self-checking bench: master rows, collision, slave modes, gating, select fault
// assumes spms_peer at the far end; pins resolved here from the enables
`timescale 1ns/100ps
module spms_port_bench;
  import spms_pkg::*;
  typedef struct packed {
    logic [7:0] ctl;
    logic dbl;
    logic [7:0] tx;
    logic [7:0] pb;
    logic [7:0] half;
  } spms_row_t;
  localparam logic [4:0] WR = 5'h01, RD = 5'h02, ST = 5'h04, CT = 5'h08, ACK = 5'h10;
  // control, double rate, own byte, peer byte, sck half period in clocks
  spms_row_t rows [8] = '{
    '{8'h50, 1'h0, 8'ha5, 8'h3c, 8'h02}, '{8'h55, 1'h0, 8'h81, 8'h7e, 8'h08},
    '{8'h5a, 1'h0, 8'h0f, 8'hf0, 8'h20}, '{8'h5f, 1'h0, 8'hc3, 8'h18, 8'h40},
    '{8'hd0, 1'h1, 8'h01, 8'h80, 8'h01}, '{8'h71, 1'h1, 8'h12, 8'h34, 8'h04},
    '{8'h52, 1'h1, 8'h55, 8'haa, 8'h10}, '{8'h53, 1'h1, 8'hfe, 8'h01, 8'h20}
  };
  logic mclk, reset, double_rate_bit, serial_power_gate_bit, ss_out_val, clock_polarity_bit, clock_phase_bit, role;
  logic dir_mosi, dir_miso, dir_sck, dir_ss, p_sck, p_ss, p_mosi, p_miso;
  logic mosi_o, mosi_oe, miso_o, miso_oe, sck_o, sck_oe, ss_n_o, ss_n_oe, irq, wake;
  logic [4:0] stb;
  logic [7:0] wv, p_tx, p_rx, rx_data, serial_status_register, serial_control_register;
  int error_cnt, num_checks;
  wire logic mosi_l = mosi_oe ? mosi_o : p_mosi;
  wire logic miso_l = miso_oe ? miso_o : p_miso;
  wire logic sck_l = sck_oe ? sck_o : p_sck;
  wire logic ss_l = ss_n_oe ? ss_n_o : p_ss;
  spms_port spms_port_i (
    .mclk, .reset, .data_wr(stb[0]), .data_wdata(wv), .data_rd(stb[1]), .stat_rd(stb[2]),
    .ctl_wr(stb[3]), .ctl_wdata(wv), .irq_ack(stb[4]), .double_rate_bit, .serial_power_gate_bit,
    .dir_mosi, .dir_miso, .dir_sck, .dir_ss, .ss_out_val, .mosi_i(mosi_l), .mosi_o, .mosi_oe,
    .miso_i(miso_l), .miso_o, .miso_oe, .sck_i(sck_l), .sck_o, .sck_oe, .ss_n_i(ss_l), .ss_n_o,
    .ss_n_oe, .rx_data, .serial_status_register, .serial_control_register, .irq, .wake
  );
  spms_peer spms_peer_i (
    .role_slave(role), .clock_polarity_bit, .clock_phase_bit, .tx_byte(p_tx), .sck(sck_l), .ss_n(ss_l), .mosi(mosi_l),
    .miso(miso_l), .sck_m(p_sck), .ss_m(p_ss), .mosi_m(p_mosi), .miso_s(p_miso), .rx(p_rx)
  );
  always #12.5 mclk = ~mclk;
  task automatic step(int n = 1);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(logic [7:0] seen, logic [7:0] exp, string what);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic strobe(logic [4:0] s, logic [7:0] v);
    step();
    stb = s;
    wv = v;
    step();
    stb = 5'h00;
  endtask
  task automatic wait_done();
    int n;
    for (n = 0; serial_status_register[STS_DONE] !== 1'h1 && n < 3000; n++)
      step();
    if (n == 3000)
    begin
      check(8'h00, 8'h01, "no completion");
      finish_test();
    end
  endtask
  function automatic logic [7:0] rev8(logic [7:0] b, logic on);
    return on ? {<<{b}} : b;
  endfunction
  initial
  begin
    spms_row_t r;
    int n;
    logic s;
    {mclk, double_rate_bit, serial_power_gate_bit, clock_polarity_bit, clock_phase_bit, dir_miso, stb, wv, p_tx} = '0;
    {reset, ss_out_val, role, dir_mosi, dir_sck, dir_ss} = '1;
    error_cnt = 0;
    num_checks = 0;
    repeat (12) @(posedge mclk);
    #1;
    reset = 1'h0;
    step();
    check(serial_control_register, CTL_RESET, "control at reset");
    check(serial_status_register, 8'h00, "status at reset");
    check({rx_data[0], irq, wake, ss_n_o}, 8'h01, "outputs at reset");
    $display("test reset done");
    foreach (rows[i])
    begin
      r = rows[i];
      {clock_polarity_bit, clock_phase_bit} = {r.ctl[CTL_CLOCK_POLARITY_BIT], r.ctl[CTL_CLOCK_PHASE_BIT]};
      double_rate_bit = r.dbl;
      p_tx = r.pb;
      strobe(CT, r.ctl);
      check(serial_status_register, {7'h00, r.dbl}, "double rate bit");
      // sck follows the new polarity one cycle after the control write; select falls after that
      step();
      check(sck_o, clock_polarity_bit, "idle sck");
      ss_out_val = 1'h0;
      step(2);
      check({ss_n_oe, ss_n_o, miso_oe, sck_oe}, 8'h09, "master pins");
      strobe(WR, r.tx);
      for (int k = 0; k < 2; k++)
        for (n = 0, s = sck_o; sck_o === s && n < 300; n++)
          step();
      check(8'(n), r.half, "sck half period");
      wait_done();
      step(3);
      check(sck_o, clock_polarity_bit, "sck stopped");
      check(rx_data, rev8(r.pb, r.ctl[CTL_LSB_FIRST]), "received byte");
      check(p_rx, rev8(r.tx, r.ctl[CTL_LSB_FIRST]), "sent byte");
      check({irq, wake}, {r.ctl[CTL_IRQ_EN], 1'h1}, "irq and wake");
      if (r.ctl[CTL_IRQ_EN])
        strobe(ACK, 8'h00);
      else
      begin
        strobe(ST, 8'h00);
        strobe(RD, 8'h00);
      end
      step();
      check({serial_status_register[STS_DONE], irq}, 8'h00, "done cleared");
      ss_out_val = 1'h1;
      $display("test master row %0d done", i);
    end
    p_tx = 8'h6c;
    strobe(CT, 8'h50);
    ss_out_val = 1'h0;
    step(2);
    strobe(WR, 8'h11);
    strobe(WR, 8'h22);
    step();
    check(serial_status_register[STS_WRITE_COLLISION_FLAG], 1'h1, "collision flag");
    wait_done();
    check(p_rx, 8'h11, "collided byte dropped");
    ss_out_val = 1'h1;
    p_tx = 8'h93;
    step(2);
    ss_out_val = 1'h0;
    step(2);
    strobe(ST, 8'h00);
    strobe(WR, 8'h44);
    step();
    check(serial_status_register[7:6], 8'h00, "flags cleared by write");
    wait_done();
    check(rx_data, 8'h93, "unread byte lost");
    check(p_rx, 8'h44, "next byte sent");
    ss_out_val = 1'h1;
    strobe(ACK, 8'h00);
    $display("test collision done");
    role = 1'h0;
    dir_miso = 1'h1;
    for (int m = 0; m < 4; m++)
    begin
      {clock_polarity_bit, clock_phase_bit} = 2'(m);
      strobe(CT, 8'hc0 | 8'(m << 2));
      strobe(WR, 8'h96 ^ 8'(m));
      step();
      check({miso_oe, mosi_oe, sck_oe, ss_n_oe}, 8'h00, "slave idle pins");
      check(serial_status_register[STS_WRITE_COLLISION_FLAG], 1'h0, "load while idle");
      spms_peer_i.send(8'hff, 8, 1'h0);
      check(serial_status_register[STS_DONE], 1'h0, "deselected shift");
      spms_peer_i.send(8'h5a + 8'(m), 8, 1'h1);
      wait_done();
      step();
      check(rx_data, 8'h5a + 8'(m), "slave received");
      check(p_rx, 8'h96 ^ 8'(m), "slave sent");
      check(irq, 1'h1, "slave irq");
      strobe(ACK, 8'h00);
      $display("test slave mode %0d done", m);
    end
    role = 1'h1;
    dir_miso = 1'h0;
    serial_power_gate_bit = 1'h1;
    strobe(CT, 8'h50);
    ss_out_val = 1'h0;
    strobe(WR, 8'h77);
    step(100);
    check(serial_status_register[STS_DONE], 1'h0, "gated port idle");
    // release the driven-low select before ungating, so only the peer can pull it low
    ss_out_val = 1'h1;
    dir_ss = 1'h0;
    step(2);
    serial_power_gate_bit = 1'h0;
    step(2);
    check(serial_status_register[STS_DONE], 1'h0, "select high keeps master");
    spms_peer_i.set_ss(1'h0);
    step(3);
    check({serial_control_register[CTL_MASTER], serial_status_register[STS_DONE]}, 8'h01, "select fault");
    spms_peer_i.set_ss(1'h1);
    $display("test gating and select fault done");
    finish_test();
  end
endmodule // spms_port_bench

// [verilog/spms_edge_det.sv]
// slave-side sck edge finder, sampled by the system clock
// assumes the external sck phases each exceed two system clocks
`timescale 1ns/100ps
module spms_edge_det (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // sck and polarity
  input wire logic sck_i,
  input wire logic clock_polarity_bit,
  // edge strobes
  output logic lead,
  output logic trail
);
  import spms_pkg::*;

  logic prev_r;
  logic prev_nxt;

  // leading edge leaves the idle level, trailing edge returns to it
  assign lead = (sck_i != prev_r) && (prev_r == clock_polarity_bit);
  assign trail = (sck_i != prev_r) && (prev_r != clock_polarity_bit);

  always_comb
  begin
    prev_nxt = sck_i;
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      prev_r <= 1'b0;
    else
      prev_r <= prev_nxt;
  end

  chk_edge_single: assert property (@(posedge mclk) disable iff (reset)
    !(lead && trail))
    else $error("sck leading and trailing edge in one cycle");

endmodule // spms_edge_det

// [verilog/spms_pkg.sv]
// constants shared by the serial master/slave port and its helpers
// assumes a single 40 MHz system clock and an asynchronous active-high reset
package spms_pkg;

  localparam int SPMS_DW = 8;
  localparam logic [3:0] SPMS_BITS = 4'h8;

  // control register field positions
  localparam int CTL_IRQ_EN = 7;
  localparam int CTL_EN = 6;
  localparam int CTL_LSB_FIRST = 5;
  localparam int CTL_MASTER = 4;
  localparam int CTL_CLOCK_POLARITY_BIT = 3;
  localparam int CTL_CLOCK_PHASE_BIT = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  localparam logic [7:0] CTL_RESET = 8'h00;

  // status register field positions
  localparam int STS_DONE = 7;
  localparam int STS_WRITE_COLLISION_FLAG = 6;
  localparam int STS_DBL = 0;

  // sck half period in system clocks for rate 0..3; double rate halves it
  localparam logic [6:0] HALF_RATE0 = 7'h02;
  localparam logic [6:0] HALF_RATE1 = 7'h08;
  localparam logic [6:0] HALF_RATE2 = 7'h20;
  localparam logic [6:0] HALF_RATE3 = 7'h40;

  // least sck phase in slave mode, in system clocks (far side must exceed it)
  localparam int SCK_MIN_PHASE_CYC = 2;

  typedef enum logic [1:0] {
    SPMS_IDLE = 2'b01,
    SPMS_RUN = 2'b10
  } spms_state_t;

endpackage

// [verilog/spms_port.sv]
// byte-wide synchronous serial port, master or slave, with cpu-side strobes
// assumes all pin inputs are synchronous to mclk; pad logic resolves the enables
//
// Overview of operation
// - port stays idle while the power gate input is high
// - data goes master to slave on mosi, slave to master on miso
// - master mode never drives select itself; software sets its level
// - master byte write runs sck, shifts eight bits, stops, sets done flag
// - completed master byte requests interrupt when irq enable is set
// - last received byte is held in a receive buffer for cpu reads
// - slave with select high stays idle and miso is not driven
// - slave may be loaded while select high; shifts only once select low
// - slave sets done flag after a full byte, interrupt if enabled
// - slave accepts new transmit byte before received byte is read
// - transmit side single buffered; writes during a shift are dropped and set the collision flag
// - receive has two stages; an unread byte is overwritten by the next
// - enabled port forces miso input as master, the rest input as slave
// - software picks lsb first or msb first
// - double rate option halves the sck period; with rate 0 it gives sck at half the system clock
// - seven distinct master bit rates are offered
// - completed transfer raises a wake request for idle sleep
// - polarity sets idle sck level; phase picks leading or trailing sample
// - master sck is clock over 4,16,64,128, halved by double rate
// - done clears on vector ack, or status read then data access
// - master with select input driven low turns slave and sets done
`timescale 1ns/100ps
module spms_port (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // cpu strobes and data
  input wire logic data_wr,
  input wire logic [spms_pkg::SPMS_DW-1:0] data_wdata,
  input wire logic data_rd,
  input wire logic stat_rd,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  input wire logic irq_ack,
  // configuration levels
  input wire logic double_rate_bit,
  input wire logic serial_power_gate_bit,
  // user pin directions and select value
  input wire logic dir_mosi,
  input wire logic dir_miso,
  input wire logic dir_sck,
  input wire logic dir_ss,
  input wire logic ss_out_val,
  // serial pins
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe,
  input wire logic sck_i,
  output logic sck_o,
  output logic sck_oe,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe,
  // cpu-visible state
  output logic [spms_pkg::SPMS_DW-1:0] rx_data,
  output logic [7:0] serial_status_register,
  output logic [7:0] serial_control_register,
  output logic irq,
  output logic wake
);
  import spms_pkg::*;

  spms_state_t st_r, st_nxt;
  logic [7:0] ctl_r, ctl_nxt;
  logic [7:0] sr_r, sr_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic out_r, out_nxt;
  logic sck_r, sck_nxt;
  logic done_r, done_nxt;
  logic write_collision_flag_r, write_collision_flag_nxt;
  logic arm_r, arm_nxt;
  logic ss_prev_r;
  logic irq_r, irq_nxt;
  logic wake_r, wake_nxt;
  logic mosi_oe_r, mosi_oe_nxt;
  logic miso_oe_r, miso_oe_nxt;
  logic sck_oe_r, sck_oe_nxt;
  logic ss_oe_r, ss_oe_nxt;
  logic ss_o_r;

  logic en, is_master, slave_act, busy, wr_ok, fault;
  logic tick, lead_s, trail_s, ev_lead, ev_trail, ev_sample, ev_setup;
  logic byte_end, set_done;
  logic [3:0] smp_after;
  logic [7:0] sr_shift;
  logic in_bit;

  // first bit to send, taken from the end that the order bit chooses
  function automatic logic top_bit(input logic [7:0] v, input logic lsb);
    top_bit = lsb ? v[0] : v[7];
  endfunction

  // shift out one end and take the received bit in at the other
  function automatic logic [7:0] shift_in(input logic [7:0] v, input logic lsb, input logic b);
    shift_in = lsb ? {b, v[7:1]} : {v[6:0], b};
  endfunction

  assign en = ctl_r[CTL_EN] && !serial_power_gate_bit;
  assign is_master = en && ctl_r[CTL_MASTER];
  assign slave_act = en && !ctl_r[CTL_MASTER] && !ss_n_i;
  // a select input pulled low in master mode means another master took the bus
  assign fault = is_master && !dir_ss && !ss_n_i;
  assign busy = (st_r == SPMS_RUN) || (slave_act && cnt_r != 4'h0);
  assign wr_ok = data_wr && !busy;
  assign in_bit = is_master ? miso_i : mosi_i;

  spms_rate_gen u_rate (
    .mclk(mclk),
    .reset(reset),
    .run(st_r == SPMS_RUN),
    .rate({ctl_r[CTL_RATE_HI], ctl_r[CTL_RATE_LO]}),
    .dbl(double_rate_bit),
    .tick(tick)
  );

  spms_edge_det u_edge (
    .mclk(mclk),
    .reset(reset),
    .sck_i(sck_i),
    .clock_polarity_bit(ctl_r[CTL_CLOCK_POLARITY_BIT]),
    .lead(lead_s),
    .trail(trail_s)
  );

  // master edges come from the divider, slave edges from the sampled pin
  always_comb
  begin
    ev_lead = 1'b0;
    ev_trail = 1'b0;
    if (is_master && st_r == SPMS_RUN)
    begin
      ev_lead = tick && (sck_r == ctl_r[CTL_CLOCK_POLARITY_BIT]);
      ev_trail = tick && (sck_r != ctl_r[CTL_CLOCK_POLARITY_BIT]);
    end
    else if (slave_act)
    begin
      ev_lead = lead_s;
      ev_trail = trail_s;
    end
    ev_sample = ctl_r[CTL_CLOCK_PHASE_BIT] ? ev_trail : ev_lead;
    ev_setup = ctl_r[CTL_CLOCK_PHASE_BIT] ? ev_lead : ev_trail;
    smp_after = ev_sample ? 4'(cnt_r + 4'h1) : cnt_r;
    sr_shift = shift_in(sr_r, ctl_r[CTL_LSB_FIRST], in_bit);
  end

  // shift engine, control register and receive buffer
  always_comb
  begin
    st_nxt = st_r;
    ctl_nxt = ctl_r;
    sr_nxt = sr_r;
    rx_nxt = rx_r;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    sck_nxt = sck_r;
    byte_end = 1'b0;
    if (ctl_wr)
      ctl_nxt = ctl_wdata;
    if (wr_ok)
      sr_nxt = data_wdata;
    if (fault)
    begin
      ctl_nxt[CTL_MASTER] = 1'b0;
      st_nxt = SPMS_IDLE;
      cnt_nxt = 4'h0;
      sck_nxt = ctl_r[CTL_CLOCK_POLARITY_BIT];
    end
    else if (is_master)
    begin
      case (st_r)
        SPMS_IDLE:
        begin
          sck_nxt = ctl_r[CTL_CLOCK_POLARITY_BIT];
          cnt_nxt = 4'h0;
          if (wr_ok)
          begin
            st_nxt = SPMS_RUN;
            if (!ctl_r[CTL_CLOCK_PHASE_BIT])
              out_nxt = top_bit(data_wdata, ctl_r[CTL_LSB_FIRST]);
          end
        end
        SPMS_RUN:
        begin
          if (tick)
            sck_nxt = !sck_r;
          if (ev_setup)
            out_nxt = top_bit(sr_r, ctl_r[CTL_LSB_FIRST]);
          if (ev_sample)
          begin
            sr_nxt = sr_shift;
            cnt_nxt = smp_after;
          end
          // the byte ends on the trailing edge after the eighth sample, or on that sample when phase samples trailing edges
          if (ev_trail && smp_after == SPMS_BITS)
          begin
            byte_end = 1'b1;
            rx_nxt = ev_sample ? sr_shift : sr_r;
            st_nxt = SPMS_IDLE;
            cnt_nxt = 4'h0;
          end
        end
        default:
        begin
          st_nxt = SPMS_IDLE;
          cnt_nxt = 4'h0;
        end
      endcase
    end
    else
    begin
      st_nxt = SPMS_IDLE;
      sck_nxt = ctl_r[CTL_CLOCK_POLARITY_BIT];
      if (!slave_act)
        cnt_nxt = 4'h0; // partial byte dropped when select rises
      else
      begin
        if (ss_prev_r && !ctl_r[CTL_CLOCK_PHASE_BIT])
          out_nxt = top_bit(sr_r, ctl_r[CTL_LSB_FIRST]);
        if (ev_setup)
          out_nxt = top_bit(sr_r, ctl_r[CTL_LSB_FIRST]);
        if (wr_ok && !ctl_r[CTL_CLOCK_PHASE_BIT])
          out_nxt = top_bit(data_wdata, ctl_r[CTL_LSB_FIRST]);
        if (ev_sample)
        begin
          sr_nxt = sr_shift;
          cnt_nxt = smp_after;
          if (smp_after == SPMS_BITS)
          begin
            byte_end = 1'b1;
            rx_nxt = sr_shift;
            cnt_nxt = 4'h0;
          end
        end
      end
    end
  end

  assign set_done = byte_end || fault;

  // flags: a hardware set in the same cycle as a clear wins
  always_comb
  begin
    done_nxt = done_r;
    write_collision_flag_nxt = write_collision_flag_r;
    arm_nxt = arm_r;
    if (irq_ack)
      done_nxt = 1'b0;
    if (arm_r && (data_rd || data_wr))
    begin
      done_nxt = 1'b0;
      write_collision_flag_nxt = 1'b0;
      arm_nxt = 1'b0;
    end
    if (stat_rd && (done_r || write_collision_flag_r))
      arm_nxt = 1'b1;
    if (set_done)
      done_nxt = 1'b1;
    if (data_wr && busy)
      write_collision_flag_nxt = 1'b1;
    irq_nxt = done_nxt && ctl_nxt[CTL_IRQ_EN];
    wake_nxt = done_nxt && ctl_nxt[CTL_EN];
  end

  // pin direction overrides; select is only ever user-driven
  always_comb
  begin
    mosi_oe_nxt = 1'b0;
    miso_oe_nxt = 1'b0;
    sck_oe_nxt = 1'b0;
    ss_oe_nxt = dir_ss;
    if (!en)
    begin
      mosi_oe_nxt = dir_mosi;
      miso_oe_nxt = dir_miso;
      sck_oe_nxt = dir_sck;
    end
    else if (ctl_nxt[CTL_MASTER])
    begin
      mosi_oe_nxt = dir_mosi;
      sck_oe_nxt = dir_sck;
    end
    else
    begin
      ss_oe_nxt = 1'b0;
      miso_oe_nxt = dir_miso && !ss_n_i;
    end
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      st_r <= SPMS_IDLE;
      ctl_r <= CTL_RESET;
      sr_r <= 8'h00;
      rx_r <= 8'h00;
      cnt_r <= 4'h0;
      out_r <= 1'b0;
      sck_r <= 1'b0;
      done_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      arm_r <= 1'b0;
      ss_prev_r <= 1'b1;
      irq_r <= 1'b0;
      wake_r <= 1'b0;
      mosi_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
      sck_oe_r <= 1'b0;
      ss_oe_r <= 1'b0;
      ss_o_r <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      ctl_r <= ctl_nxt;
      sr_r <= sr_nxt;
      rx_r <= rx_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
      sck_r <= sck_nxt;
      done_r <= done_nxt;
      write_collision_flag_r <= write_collision_flag_nxt;
      arm_r <= arm_nxt;
      ss_prev_r <= ss_n_i;
      irq_r <= irq_nxt;
      wake_r <= wake_nxt;
      mosi_oe_r <= mosi_oe_nxt;
      miso_oe_r <= miso_oe_nxt;
      sck_oe_r <= sck_oe_nxt;
      ss_oe_r <= ss_oe_nxt;
      ss_o_r <= ss_out_val;
    end
  end

  assign mosi_o = out_r;
  assign miso_o = out_r;
  assign sck_o = sck_r;
  assign mosi_oe = mosi_oe_r;
  assign miso_oe = miso_oe_r;
  assign sck_oe = sck_oe_r;
  assign ss_n_o = ss_o_r;
  assign ss_n_oe = ss_oe_r;
  assign rx_data = rx_r;
  assign serial_status_register = {done_r, write_collision_flag_r, 5'h00, double_rate_bit};
  assign serial_control_register = ctl_r;
  assign irq = irq_r;
  assign wake = wake_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence seq_arm;
    stat_rd && done_r && !data_rd && !data_wr;
  endsequence

  sequence seq_access;
    data_rd && !set_done && !stat_rd;
  endsequence

  chk_gate_idle: assert property (serial_power_gate_bit |=> st_r == SPMS_IDLE)
    else $error("port left idle while power gate set");
  chk_miso_hiz: assert property ((en && !ctl_nxt[CTL_MASTER] && ss_n_i) |=> !miso_oe)
    else $error("miso driven in slave mode with select high");
  chk_master_start: assert property ((is_master && !fault && st_r == SPMS_IDLE && wr_ok) |=> st_r == SPMS_RUN)
    else $error("master write did not start a byte");
  chk_byte_done: assert property (byte_end |=> done_r && rx_data == $past(rx_nxt))
    else $error("byte end did not set done and load receive buffer");
  chk_irq_follow: assert property (irq == (done_r && ctl_r[CTL_IRQ_EN]))
    else $error("interrupt request disagrees with done flag and enable");
  chk_write_collision_flag_busy: assert property ((data_wr && busy && !byte_end && !fault) |=> write_collision_flag_r && $stable(st_r))
    else $error("write during transfer did not flag collision");
  chk_mode_fault: assert property (fault |=> !ctl_r[CTL_MASTER] && done_r && st_r == SPMS_IDLE)
    else $error("select low in master mode did not turn port slave");
  chk_miso_in_master: assert property ((en && ctl_nxt[CTL_MASTER]) |=> !miso_oe)
    else $error("miso driven while master");
  chk_rx_hold: assert property (!byte_end |=> $stable(rx_data))
    else $error("receive buffer changed without a byte end");
  // cpu strobes come one idle cycle apart, so the access follows the status read two cycles on
  chk_flag_clear: assert property ((seq_arm ##2 seq_access) |=> !done_r && !write_collision_flag_r)
    else $error("status read then data access did not clear flags");
  chk_master_len: assert property ((st_r == SPMS_IDLE && $past(st_r) == SPMS_RUN && $past(is_master)
    && !$past(fault)) |-> $past(cnt_r) >= 4'h7)
    else $error("master byte ended before eight samples");

endmodule // spms_port

// [verilog/spms_rate_gen.sv]
// master sck half-period tick generator
// assumes run is held for the whole byte and drops when the byte ends
`timescale 1ns/100ps
module spms_rate_gen (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // control
  input wire logic run,
  input wire logic [1:0] rate,
  input wire logic dbl,
  // half-period strobe
  output logic tick
);
  import spms_pkg::*;

  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] half;

  function automatic logic [6:0] half_period(input logic [1:0] r, input logic d);
    logic [6:0] base;
    base = HALF_RATE0;
    case (r)
      2'h0: base = HALF_RATE0;
      2'h1: base = HALF_RATE1;
      2'h2: base = HALF_RATE2;
      default: base = HALF_RATE3;
    endcase
    half_period = d ? (base >> 1) : base;
  endfunction

  // four divisors and their halves give seven distinct rates
  assign half = half_period(rate, dbl);
  assign tick = run && (cnt_r == 7'(half - 7'h01));

  always_comb
  begin
    cnt_nxt = cnt_r;
    if (!run || tick)
      cnt_nxt = 7'h00;
    else
      cnt_nxt = 7'(cnt_r + 7'h01);
  end

  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
      cnt_r <= 7'h00;
    else
      cnt_r <= cnt_nxt;
  end

  chk_tick_gap: assert property (@(posedge mclk) disable iff (reset)
    (tick && half > 7'h01) |=> !tick)
    else $error("sck ticks closer than the selected half period");

endmodule // spms_rate_gen
